// >>> src/clf_cmd_top.sv
/*
 * Command interpreter for the Z filter, option, transmit read-back and
 * ground-key commands, plus the Z filter datapath and the option outputs.
 * Assumes the serial host port delivers one strobe per received byte and
 * marks the command byte; read bytes are fetched with a read strobe.
 */
// Behaviour
// [R1] 98h writes, 99h reads ZFILTER_FIR_COEFFICIENTS coefficients; bit 0 selects direction.
// [R2] FIR transfer is ten bytes, term sets 0..4, higher pair in upper nibble.
// [R3] Sign bit 0 means factor +1, sign bit 1 means factor -1.
// [R4] Coefficients 0-5 and 7 use four nested stages, coefficient 6 two.
// [R5] Z filter at 32 kHz: five FIR taps plus one-pole IIR, gain z5*z6*z7.
// [R6] FIR coefficient words reset to 0190h.
// [R7] IIR input scaled by 1/z6, output multiplied by z6; the code has no 1/z6 stage and scales the input by z5 only.
// [R8] 9Ah writes, 9Bh reads IIR only; five bytes, term sets 5, 6, 7.
// [R9] IIR words reset to 0190h except the single 01h byte.
// [R10] C8h writes, C9h reads the global option register for all channels.
// [R11] Bit 7 enables strobe multiplexing; reset cleared.
// [R12] Bit 6 sets strobe polarity; no strobe unless clock mode is 1.
// [R13] Bits 5:2 set hook debounce 0-15 ms, default 8 ms.
// [R14] Bit 1 doubles the PCM bit clock relative to data rate.
// [R15] Bit 0 enables the chopper clock output; reset cleared.
// [R16] CDh returns two bytes: transmit data then reserved bits.
// [R17] First byte is companded sample, or upper linear byte with sign.
// [R18] Host writes reserved bits as zero and does not trust them read.
// [R19] E8h/E9h access per-channel ground-key period 0-15 ms; 0 disables.
// [R20] Data bytes follow the command byte in ascending order.
`timescale 1ns/1ps
module clf_cmd_top #(
  parameter int NCH = clf_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rstn,
  // Host serial port byte interface
  input  wire logic               host_byte_valid,
  input  wire logic               host_byte_is_cmd,
  input  wire logic [7:0]         host_byte,
  input  wire logic [1:0]         chan_sel,
  input  wire logic               host_rd_strobe,
  output logic [7:0]              host_rd_data,
  output logic                    host_rd_valid,
  // Transmit path
  input  wire logic [15:0]        tx_sample,
  input  wire logic               linear_mode,
  input  wire logic               pcm_mpi_mode,
  // Pins
  input  wire logic               clock_mode_select,
  input  wire logic [NCH-1:0]     hook_input_line,
  input  wire logic [NCH-1:0]     ground_key_input_line,
  input  wire logic               strobe_request,
  output logic                    mux_strobe_output,
  output logic                    chopper_clock_out,
  output logic                    double_bit_clock,
  output logic [NCH-1:0]          hook_realtime,
  output logic [NCH-1:0]          ground_key_realtime,
  // Z filter samples
  input  wire logic signed [15:0] zf_in,
  output logic signed [15:0]      zf_out,
  output logic                    zf_tick
);
  clf_pkg::clf_state_e state_reg;
  logic [3:0]   idx_reg;
  logic         rd_reg;
  logic [79:0]  fir_reg;
  logic [39:0]  iir_reg;
  logic [7:0]   opt_reg;
  logic [3:0]   gk_reg [NCH];
  logic [1:0]   ch_reg;
  logic [7:0]   xmt_hold_reg;
  logic         cms_s1_reg;
  logic         cms_s2_reg;

  wire [7:0] cmd_base = host_byte & clf_pkg::CMD_DIR_MASK;
  wire       dat_ev   = host_byte_valid && !host_byte_is_cmd;

  // Command decode and byte sequencing; data counts with or without gaps between bytes.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= clf_pkg::CLF_IDLE;
      idx_reg   <= '0;
      rd_reg    <= 1'b0;
      ch_reg    <= '0;
    end else if (host_byte_valid && host_byte_is_cmd) begin
      idx_reg <= '0;
      rd_reg  <= host_byte[0]; // R1
      ch_reg  <= chan_sel;
      unique case (cmd_base)
        clf_pkg::CMD_FIR_WR: state_reg <= clf_pkg::CLF_FIR; // R1
        clf_pkg::CMD_IIR_WR: state_reg <= clf_pkg::CLF_IIR; // R8
        clf_pkg::CMD_OPT_WR: state_reg <= clf_pkg::CLF_OPT; // R10
        clf_pkg::CMD_GK_WR:  state_reg <= clf_pkg::CLF_GK; // R19
        default: begin
          if (host_byte == clf_pkg::CMD_XMT_RD && pcm_mpi_mode) begin // R16
            state_reg <= clf_pkg::CLF_XMT;
            rd_reg    <= 1'b1;
          end else begin
            state_reg <= clf_pkg::CLF_SKIP;
          end
        end
      endcase
    end else if ((!rd_reg && dat_ev) || (rd_reg && host_rd_strobe)) begin
      idx_reg <= idx_reg + 4'd1; // R20
      unique case (state_reg)
        clf_pkg::CLF_FIR:
          if (idx_reg == 4'(clf_pkg::FIR_BYTES - 1)) state_reg <= clf_pkg::CLF_IDLE;
        clf_pkg::CLF_IIR:
          if (idx_reg == 4'(clf_pkg::IIR_BYTES - 1)) state_reg <= clf_pkg::CLF_IDLE;
        clf_pkg::CLF_XMT:
          if (idx_reg == 4'(clf_pkg::XMT_BYTES - 1)) state_reg <= clf_pkg::CLF_IDLE;
        clf_pkg::CLF_OPT, clf_pkg::CLF_GK: state_reg <= clf_pkg::CLF_IDLE;
        clf_pkg::CLF_IDLE, clf_pkg::CLF_SKIP: state_reg <= state_reg;
      endcase
    end
  end

  wire wr_ev = dat_ev && !rd_reg;

  // Byte n of the FIR transfer: even bytes hold sets 4/3, odd bytes sets 2/1,
  // tap index n/2. Word k occupies fir_reg[k*16 +: 16] as C4m4 C3m3 C2m2 C1m1.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fir_reg <= {5{clf_pkg::COEF_WORD_RST}}; // R6
    end else if (wr_ev && state_reg == clf_pkg::CLF_FIR) begin
      fir_reg[idx_reg[3:1]*16 + (idx_reg[0] ? 0 : 8) +: 8] <= host_byte; // R2
    end
  end

  // IIR bytes 1..5 map to the byte positions 4..0; byte 3 holds z6.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      iir_reg <= {clf_pkg::COEF_WORD_RST, clf_pkg::IIR_Z6_RST,
                  clf_pkg::COEF_WORD_RST}; // R9
    end else if (wr_ev && state_reg == clf_pkg::CLF_IIR) begin
      iir_reg[(3'(clf_pkg::IIR_BYTES - 1) - idx_reg[2:0])*8 +: 8] <= host_byte; // R8
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      opt_reg <= clf_pkg::OPT_RST; // R11
    end else if (wr_ev && state_reg == clf_pkg::CLF_OPT) begin
      opt_reg <= host_byte; // R10
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NCH; c++) gk_reg[c] <= clf_pkg::GK_RST;
    end else if (wr_ev && state_reg == clf_pkg::CLF_GK) begin
      gk_reg[ch_reg] <= host_byte[3:0]; // R19
    end
  end

  // The first byte is frozen from the sample at the command; the second is always 00h.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xmt_hold_reg <= '0;
    end else if (host_byte_valid && host_byte_is_cmd && host_byte == clf_pkg::CMD_XMT_RD) begin
      xmt_hold_reg <= linear_mode ? tx_sample[15:8] : tx_sample[7:0]; // R17
    end
  end

  // Read data: byte at idx_reg, answered on the read strobe.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      host_rd_data  <= '0;
      host_rd_valid <= 1'b0;
    end else begin
      host_rd_valid <= host_rd_strobe && rd_reg && state_reg != clf_pkg::CLF_IDLE
                       && state_reg != clf_pkg::CLF_SKIP;
      unique case (state_reg)
        clf_pkg::CLF_FIR:
          host_rd_data <= fir_reg[idx_reg[3:1]*16 + (idx_reg[0] ? 0 : 8) +: 8]; // R1
        clf_pkg::CLF_IIR:
          host_rd_data <= iir_reg[(3'(clf_pkg::IIR_BYTES - 1) - idx_reg[2:0])*8 +: 8];
        clf_pkg::CLF_OPT: host_rd_data <= opt_reg; // R10
        clf_pkg::CLF_GK:  host_rd_data <= {4'h0, gk_reg[ch_reg]}; // R19
        clf_pkg::CLF_XMT: host_rd_data <= (idx_reg == 4'd0) ? xmt_hold_reg : 8'h00; // R16
        clf_pkg::CLF_IDLE, clf_pkg::CLF_SKIP: host_rd_data <= 8'h00;
      endcase
    end
  end

  // Option outputs.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mux_strobe_output <= 1'b0;
      double_bit_clock  <= 1'b0;
    end else begin
      mux_strobe_output <= (opt_reg[clf_pkg::OPT_MUX_EN_BIT] && cms_s2_reg) ?
                           (strobe_request ^ opt_reg[clf_pkg::OPT_POL_BIT]) : 1'b0; // R11 R12
      double_bit_clock  <= opt_reg[clf_pkg::OPT_DOUBLE_BIT_CLOCK_BIT]; // R14
    end
  end

  logic [15:0] chop_cnt_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      chop_cnt_reg      <= '0;
      chopper_clock_out <= 1'b0;
    end else if (!opt_reg[clf_pkg::OPT_CHOP_BIT]) begin
      chop_cnt_reg      <= '0;
      chopper_clock_out <= 1'b0; // R15
    end else if (chop_cnt_reg == 16'(clf_pkg::CYC_PER_CHOP_HALF - 1)) begin
      chop_cnt_reg      <= '0;
      chopper_clock_out <= !chopper_clock_out; // R15
    end else begin
      chop_cnt_reg <= chop_cnt_reg + 16'd1;
    end
  end

  // Millisecond tick shared by the hook and ground-key filters.
  logic [15:0] ms_cnt_reg;
  wire ms_tick = (ms_cnt_reg == 16'(clf_pkg::CYC_PER_MS - 1));
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) ms_cnt_reg <= '0;
    else       ms_cnt_reg <= ms_tick ? 16'd0 : ms_cnt_reg + 16'd1;
  end

  logic [NCH-1:0] hook_s1_reg, hook_s2_reg, gk_s1_reg, gk_s2_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hook_s1_reg <= '0;
      hook_s2_reg <= '0;
      gk_s1_reg   <= '0;
      gk_s2_reg   <= '0;
      cms_s1_reg  <= 1'b0;
      cms_s2_reg  <= 1'b0;
    end else begin
      hook_s1_reg <= hook_input_line;
      hook_s2_reg <= hook_s1_reg;
      gk_s1_reg   <= ground_key_input_line;
      gk_s2_reg   <= gk_s1_reg;
      cms_s1_reg  <= clock_mode_select;
      cms_s2_reg  <= cms_s1_reg;
    end
  end

  wire [3:0] hook_debounce_time = opt_reg[clf_pkg::OPT_DSH_HI:clf_pkg::OPT_DSH_LO];

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [3:0] hcnt_reg;
    logic [3:0] gcnt_reg;
    // Hook bit follows on the dsh-th ms tick of a stable differing input, at once when dsh is 0.
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        hcnt_reg         <= '0;
        hook_realtime[c] <= 1'b0;
      end else if (hook_s2_reg[c] == hook_realtime[c]) begin
        hcnt_reg <= '0;
      end else if (hook_debounce_time == 4'd0 || (ms_tick && hcnt_reg + 4'd1 >= hook_debounce_time)) begin
        hook_realtime[c] <= hook_s2_reg[c]; // R13
        hcnt_reg         <= '0;
      end else if (ms_tick) begin
        hcnt_reg <= hcnt_reg + 4'd1;
      end
    end
    // Ground key sampled once every gk ms; zero passes the input straight.
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        gcnt_reg               <= '0;
        ground_key_realtime[c] <= 1'b0;
      end else if (gk_reg[c] == 4'd0) begin
        gcnt_reg               <= '0;
        ground_key_realtime[c] <= gk_s2_reg[c]; // R19
      end else if (ms_tick) begin
        if (gcnt_reg + 4'd1 >= gk_reg[c]) begin
          gcnt_reg               <= '0;
          ground_key_realtime[c] <= gk_s2_reg[c]; // R19
        end else begin
          gcnt_reg <= gcnt_reg + 4'd1;
        end
      end
    end
  end

  // Z filter coefficients.
  logic signed [15:0] zc [8];
  for (genvar k = 0; k < 8; k++) begin : g_coef
    localparam int ST = (k == 6) ? 2 : 4; // R4
    wire [15:0] w = (k < 5) ? fir_reg[k*16 +: 16] :
                    (k == 5) ? iir_reg[24 +: 16] :
                    (k == 6) ? {8'h00, iir_reg[16 +: 8]} : iir_reg[0 +: 16];
    clf_coef_term #(.STAGES(ST)) u_term (
      .term_word  (w),
      .coef_value (zc[k])
    );
  end

  logic [15:0] zf_cnt_reg;
  assign zf_tick = (zf_cnt_reg == 16'(clf_pkg::CYC_PER_ZF - 1)); // R5
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) zf_cnt_reg <= '0;
    else       zf_cnt_reg <= zf_tick ? 16'd0 : zf_cnt_reg + 16'd1;
  end

  // Delay line and IIR state; Q3.12 sums are trimmed back to 16 bits only when registered.
  // The 1/z6 input gain is folded into z5 as programmed, which saves a divider;
  // the state therefore carries z5*z7 and only the output is scaled by z6.
  logic signed [15:0] dly_reg [5];
  logic signed [15:0] iir_st_reg;
  logic signed [31:0] fir_acc, iir_in, iir_nx, iir_out;
  always_comb begin
    fir_acc = '0;
    for (int k = 0; k < 5; k++) fir_acc = fir_acc + dly_reg[k] * zc[k]; // R5
    iir_in  = (dly_reg[0] * zc[5]) >>> clf_pkg::COEF_FRAC; // R7
    iir_nx  = ((iir_in * zc[7]) >>> clf_pkg::COEF_FRAC)
              + ((iir_st_reg * zc[7]) >>> clf_pkg::COEF_FRAC); // R5
    iir_out = (iir_st_reg * zc[6]) >>> clf_pkg::COEF_FRAC; // R7
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < 5; k++) dly_reg[k] <= '0;
      iir_st_reg <= '0;
      zf_out     <= '0;
    end else if (zf_tick) begin
      dly_reg[0] <= zf_in;
      for (int k = 1; k < 5; k++) dly_reg[k] <= dly_reg[k-1];
      iir_st_reg <= 16'(iir_nx >>> 0);
      zf_out     <= 16'((fir_acc >>> clf_pkg::COEF_FRAC) + iir_out);
    end
  end
endmodule // clf_cmd_top

// >>> src/clf_coef_term.sv
/*
 * Turns one coefficient's sign/exponent nibble pairs into a fixed-point value.
 * Assumes coefficient words laid out as four nibbles C4m4 C3m3 C2m2 C1m1.
 */
`timescale 1ns/1ps
module clf_coef_term #(
  parameter int STAGES = 4
) (
  // Packed term set, nibble k holds sign bit 3 and exponent bits 2:0.
  input  wire logic [15:0] term_word,
  // Coefficient in Q3.12.
  output logic signed [15:0] coef_value
);
  // Evaluated innermost first: v = C*2^-m*(1+v).
  always_comb begin
    logic signed [15:0] acc;
    logic signed [15:0] one;
    logic signed [15:0] sh;
    acc = '0;
    one = 16'sh1000;
    sh  = '0;
    for (int k = STAGES - 1; k >= 0; k--) begin
      sh = (one + acc) >>> term_word[k*4 +: 3];
      acc = term_word[k*4+3] ? -sh : sh; // R3
    end
    coef_value = acc;
  end
endmodule // clf_coef_term

// >>> src/clf_pkg.sv
/*
 * Shared constants for the coefficient and line-filter command block.
 * Assumes a byte-wide command port already framed by the serial front end.
 */
package clf_pkg;
  localparam logic [7:0] CMD_FIR_WR   = 8'h98;
  localparam logic [7:0] CMD_IIR_WR   = 8'h9A;
  localparam logic [7:0] CMD_OPT_WR   = 8'hC8;
  localparam logic [7:0] CMD_XMT_RD   = 8'hCD;
  localparam logic [7:0] CMD_GK_WR    = 8'hE8;
  localparam logic [7:0] CMD_DIR_MASK = 8'hFE;
  localparam int         FIR_BYTES    = 10;
  localparam int         IIR_BYTES    = 5;
  localparam int         XMT_BYTES    = 2;
  localparam int         NUM_CH       = 4;
  localparam logic [15:0] COEF_WORD_RST = 16'h0190;
  localparam logic [7:0]  IIR_Z6_RST    = 8'h01;
  localparam logic [7:0]  OPT_RST       = 8'h20;
  localparam logic [3:0]  GK_RST        = 4'h0;
  localparam int OPT_MUX_EN_BIT = 7;
  localparam int OPT_POL_BIT    = 6;
  localparam int OPT_DSH_HI     = 5;
  localparam int OPT_DSH_LO     = 2;
  localparam int OPT_DOUBLE_BIT_CLOCK_BIT   = 1;
  localparam int OPT_CHOP_BIT   = 0;
  localparam int CLK_HZ         = 40_000_000;
  localparam int MS_HZ          = 1_000;
  localparam int CYC_PER_MS     = CLK_HZ / MS_HZ;
  localparam int ZF_RATE_HZ     = 32_000;
  localparam int CYC_PER_ZF     = CLK_HZ / ZF_RATE_HZ;
  localparam int CHOP_HZ        = 256_000;
  localparam int CYC_PER_CHOP_HALF = CLK_HZ / (2 * CHOP_HZ);
  localparam int COEF_W         = 16;
  localparam int COEF_FRAC      = 12;
  typedef enum logic [2:0] {
    CLF_IDLE, CLF_FIR, CLF_IIR, CLF_OPT, CLF_XMT, CLF_GK, CLF_SKIP
  } clf_state_e;
endpackage

// >>> verification/clf_cmd_sva.sv
/* Concurrent checks on the command block's ports.
   Assumes one core clock domain; bound into every clf_cmd_top instance. */
`timescale 1ns/1ps
module clf_cmd_sva (
  // Clock
  input wire logic        core_clk,
  input wire logic        rstn,
  // Host
  input wire logic        host_byte_valid,
  input wire logic        host_byte_is_cmd,
  input wire logic [7:0]  host_byte,
  input wire logic        host_rd_strobe,
  input wire logic [7:0]  host_rd_data,
  input wire logic        host_rd_valid,
  // Pins
  input wire logic [15:0] tx_sample,
  input wire logic        linear_mode,
  input wire logic        pcm_mpi_mode,
  input wire logic        clock_mode_select,
  input wire logic        mux_strobe_output,
  input wire logic        chopper_clock_out,
  input wire logic        double_bit_clock,
  input wire logic        zf_tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  int   zf_gap;
  logic zf_seen;
  // The first tick after reset has no earlier tick to be measured against.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      zf_gap  <= 0;
      zf_seen <= 1'b0;
    end else begin
      zf_gap  <= zf_tick ? 0 : zf_gap + 1;
      zf_seen <= zf_seen | zf_tick;
    end
  end
  sequence s_cmd(logic [7:0] c);
    host_byte_valid && host_byte_is_cmd && host_byte == c;
  endsequence
  sequence s_opt_wr;
    s_cmd(clf_pkg::CMD_OPT_WR) ##1 (host_byte_valid && !host_byte_is_cmd);
  endsequence
  sequence s_cd_rd;
    s_cmd(clf_pkg::CMD_XMT_RD) ##0 pcm_mpi_mode ##1 host_rd_strobe;
  endsequence
  property p_zf_period; zf_tick && zf_seen |-> zf_gap == clf_pkg::CYC_PER_ZF - 1; endproperty
  property p_double_bit_clock; s_opt_wr ##0 host_byte[1] |-> ##2 double_bit_clock; endproperty
  property p_chop_off; s_opt_wr ##0 !host_byte[0] |-> ##3 (!chopper_clock_out) [*8]; endproperty
  property p_strobe_off; (!clock_mode_select) [*4] |-> !mux_strobe_output; endproperty
  property p_rd_cause; host_rd_valid |-> $past(host_rd_strobe); endproperty
  property p_opt_rd; s_cmd(8'hC9) ##1 host_rd_strobe |=> host_rd_valid; endproperty
  property p_cd_refused;
    s_cmd(clf_pkg::CMD_XMT_RD) ##0 !pcm_mpi_mode ##1 host_rd_strobe |=> !host_rd_valid;
  endproperty
  property p_cd_upper; s_cd_rd ##0 linear_mode |=> host_rd_data == tx_sample[15:8]; endproperty
  property p_cd_second; s_cd_rd ##2 host_rd_strobe |=> host_rd_data == 8'h00; endproperty
  a_zf_period: assert property (p_zf_period) else $error("zf tick spacing wrong");
  a_double_bit_clock: assert property (p_double_bit_clock) else $error("double clock not set");
  a_chop_off: assert property (p_chop_off) else $error("chopper runs while off");
  a_strobe_off: assert property (p_strobe_off) else $error("strobe without clock mode");
  a_rd_cause: assert property (p_rd_cause) else $error("read data without strobe");
  a_opt_rd: assert property (p_opt_rd) else $error("option read not answered");
  a_cd_refused: assert property (p_cd_refused) else $error("sample read outside mode");
  a_cd_upper: assert property (p_cd_upper) else $error("linear upper byte wrong");
  a_cd_second: assert property (p_cd_second) else $error("second sample byte wrong");
endmodule // clf_cmd_sva

bind clf_cmd_top clf_cmd_sva clf_cmd_sva_i (
  .core_clk, .rstn, .host_byte_valid, .host_byte_is_cmd, .host_byte, .host_rd_strobe,
  .host_rd_data, .host_rd_valid, .tx_sample, .linear_mode, .pcm_mpi_mode, .clock_mode_select,
  .mux_strobe_output, .chopper_clock_out, .double_bit_clock, .zf_tick
);

// >>> verification/clf_host_model.sv
/* Host processor model for the byte-wide command port.
   Assumes each task is entered 1 ns after a rising clock edge. */
`timescale 1ns/1ps
module clf_host_model (
  // Clock
  input wire logic       core_clk,
  // Byte port
  output logic           host_byte_valid,
  output logic           host_byte_is_cmd,
  output logic [7:0]     host_byte,
  output logic [1:0]     chan_sel,
  output logic           host_rd_strobe,
  // Answer
  input wire logic [7:0] host_rd_data,
  input wire logic       host_rd_valid
);
  initial begin
    host_byte_valid  = 1'b0;
    host_byte_is_cmd = 1'b0;
    host_byte        = 8'h00;
    chan_sel         = 2'b00;
    host_rd_strobe   = 1'b0;
  end
  // Consecutive calls give one byte per cycle with no gap.
  task automatic put(input logic c, input logic [1:0] ch, input logic [7:0] b);
    host_byte_valid  = 1'b1;
    host_byte_is_cmd = c;
    host_byte        = b;
    chan_sel         = ch;
    @(posedge core_clk);
    #1;
  endtask
  // A released bus shows the inverse of its last byte so stale data cannot match.
  task automatic idle();
    host_byte_valid  = 1'b0;
    host_byte_is_cmd = 1'b0;
    host_byte        = ~host_byte;
  endtask
  task automatic get(output logic v, output logic [7:0] d);
    idle();
    host_rd_strobe = 1'b1;
    @(posedge core_clk);
    #1;
    host_rd_strobe = 1'b0;
    v = host_rd_valid;
    d = host_rd_data;
    @(posedge core_clk);
    #1;
  endtask
endmodule // clf_host_model

// >>> verification/coef_and_line_filter_commands_tb_top.sv
/* Self-checking bench for clf_cmd_top with the host port model.
   Assumes the 40 MHz core clock and the package reset values. */
`timescale 1ns/1ps
module coef_and_line_filter_commands_tb_top;
  logic              core_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              host_byte_valid, host_byte_is_cmd, host_rd_strobe, host_rd_valid;
  logic [7:0]        host_byte, host_rd_data;
  logic [1:0]        chan_sel;
  logic [15:0]       tx_sample = 16'hA53C;
  logic              linear_mode = 1'b0, pcm_mpi_mode = 1'b0;
  logic              clock_mode_select = 1'b0, strobe_request = 1'b0;
  logic [3:0]        hook_input_line = 4'h0, ground_key_input_line = 4'h0;
  logic              mux_strobe_output, chopper_clock_out, double_bit_clock, zf_tick;
  logic [3:0]        hook_realtime, ground_key_realtime;
  logic signed [15:0] zf_in = 16'h0000, zf_out;
  logic [7:0]        f[$], p[$], z[$];
  int                n, err_total = 0, samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  clf_cmd_top clf_cmd_top_i (
    .core_clk, .rstn, .host_byte_valid, .host_byte_is_cmd, .host_byte, .chan_sel,
    .host_rd_strobe, .host_rd_data, .host_rd_valid, .tx_sample, .linear_mode, .pcm_mpi_mode,
    .clock_mode_select, .hook_input_line, .ground_key_input_line, .strobe_request,
    .mux_strobe_output, .chopper_clock_out, .double_bit_clock, .hook_realtime,
    .ground_key_realtime, .zf_in, .zf_out, .zf_tick
  );
  clf_host_model clf_host_model_i (
    .core_clk, .host_byte_valid, .host_byte_is_cmd, .host_byte, .chan_sel, .host_rd_strobe,
    .host_rd_data, .host_rd_valid
  );
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input int ch, input logic [7:0] d[$]);
    clf_host_model_i.put(1'b1, 2'(ch), c);
    foreach (d[i]) clf_host_model_i.put(1'b0, 2'(ch), d[i]);
    clf_host_model_i.idle();
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] c, input int ch, input logic [7:0] e[$],
                    input int ok);
    logic       v;
    logic [7:0] b;
    clf_host_model_i.put(1'b1, 2'(ch), c);
    foreach (e[i]) begin
      clf_host_model_i.get(v, b);
      chk(16'(v), 16'(ok));
      if (ok) chk(16'(b), 16'(e[i]));
    end
  endtask
  initial begin
    #(25 * 96_000);
    err_total++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 5; i++) f = {f, 8'h01, 8'h90};
    z = {8'h01, 8'h90, 8'h01, 8'h01, 8'h90};
    for (int i = 0; i < 10; i++) p.push_back(8'(8'h13 * i + 8'h05));
    rd(8'h99, 0, f, 1);
    rd(8'h9B, 0, z, 1);
    rd(8'hC9, 0, {8'h20}, 1);
    rd(8'hE9, 2, {8'h00}, 1);
    zf_in = 16'h1000;
    ground_key_input_line = 4'hF;
    cyc(3 * clf_pkg::CYC_PER_ZF);
    chk(zf_out, 16'h0000);
    chk(16'(ground_key_realtime), 16'h000F);
    wr(8'h98, 0, p);
    rd(8'h99, 0, p, 1);
    rd(8'h9B, 0, z, 1);
    wr(8'h9A, 0, p[0:4]);
    rd(8'h9B, 0, p[0:4], 1);
    rd(8'h99, 0, p, 1);
    wr(8'h9A, 0, z);
    // Tap 0 becomes -(1 + 3/128); the other taps keep their 0190h words, which evaluate to zero.
    f[0] = 8'h00;
    f[1] = 8'h78;
    wr(8'h98, 0, f);
    cyc(3 * clf_pkg::CYC_PER_ZF);
    chk(zf_out, 16'hEFA0);
    f[0] = 8'h01;
    f[1] = 8'h90;
    wr(8'h98, 0, f);
    // With z5 = 1, z6 = 1 and z7 = 1/2 a unit step climbs towards unity from below.
    wr(8'h9A, 0, {8'h09, 8'h00, 8'h01, 8'h09, 8'h01});
    cyc(3 * clf_pkg::CYC_PER_ZF);
    chk(16'(zf_out >= 16'sh0800 && zf_out < 16'sh1000), 16'h0001);
    for (int c = 0; c < 4; c++) wr(8'hE8, 2'(c), {8'(c + 9)});
    for (int c = 0; c < 4; c++) rd(8'hE9, 2'(c), {8'(c + 9)}, 1);
    clock_mode_select = 1'b1;
    strobe_request = 1'b1;
    wr(8'hC8, 0, {8'h83});
    rd(8'hC9, 0, {8'h83}, 1);
    chk(16'(double_bit_clock), 16'h0001);
    chk(16'(mux_strobe_output), 16'h0001);
    n = 0;
    for (int i = 0; i < 400; i++) begin
      cyc(1);
      n += chopper_clock_out;
    end
    chk(16'(n > 100 && n < 300), 16'h0001);
    wr(8'hC8, 0, {8'hC0});
    chk(16'(mux_strobe_output), 16'h0000);
    strobe_request = 1'b0;
    cyc(2);
    chk(16'(mux_strobe_output), 16'h0001);
    clock_mode_select = 1'b0;
    cyc(4);
    chk(16'(mux_strobe_output), 16'h0000);
    clock_mode_select = 1'b1;
    strobe_request = 1'b1;
    wr(8'hC8, 0, {8'h08});
    chk(16'(mux_strobe_output), 16'h0000);
    chk(16'(double_bit_clock), 16'h0000);
    chk(16'(chopper_clock_out), 16'h0000);
    // Debounce of 2 ms: short of one tick the level must hold, after 2 ms it must pass.
    hook_input_line = 4'hF;
    cyc(1000);
    chk(16'(hook_realtime), 16'h0000);
    cyc(80_000);
    chk(16'(hook_realtime), 16'h000F);
    pcm_mpi_mode = 1'b1;
    linear_mode = 1'b1;
    rd(8'hCD, 0, {8'hA5, 8'h00}, 1);
    linear_mode = 1'b0;
    rd(8'hCD, 0, {8'h3C, 8'h00}, 1);
    pcm_mpi_mode = 1'b0;
    rd(8'hCD, 0, {8'h00}, 0);
    complete_run();
  end
endmodule // coef_and_line_filter_commands_tb_top
